//--- ess_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// External scan sequencer top
module ess_sequencer
    import ess_pkg::*;
#(
    parameter int DEPTH       = 64,
    parameter int MS_DIV      = MS_CYCLES,
    parameter int PULSE_W     = PULSE_CYCLES
)(
    input  wire logic                core_clk_i,
    input  wire logic                arst_n_i,
    input  wire logic                scan_start_i,
    input  wire logic                internal_meter_on_i,
    input  wire logic [NUM_CH-1:0]   scan_list_i,
    input  wire logic [NUM_CH-1:0]   digital_ch_i,
    input  wire logic                paired_sense_enable_i,
    input  wire logic                narrow_module_i,
    input  wire logic                cfg_wr_i,
    input  wire logic [1:0]          sweep_source_select_i,
    input  wire logic [1:0]          step_source_select_i,
    input  wire logic [15:0]         sweep_total_setting_i,
    input  wire logic                delay_wr_i,
    input  wire logic [CH_BITS-1:0]  delay_ch_i,
    input  wire logic [15:0]         delay_ms_i,
    input  wire logic                timer_tick_i,
    input  wire logic [3:0]          src_event_i,
    input  wire logic [DATA_W-1:0]   digital_data_i,
    input  wire logic                fetch_i,
    input  wire logic [15:0]         fetch_idx_i,
    input  wire logic                remove_i,
    input  wire logic [CH_BITS-1:0]  query_ch_i,
    input  wire logic                stats_reset_request_i,
    output logic                     settled_o,
    output logic                     scanning_o,
    output logic [CH_BITS-1:0]       chan_o,
    output logic [CH_BITS-1:0]       sense_chan_o,
    output logic                     cfg_err_o,
    output logic [15:0]              sweep_done_o,
    output logic [DATA_W-1:0]        rd_data_o,
    output logic [15:0]              stored_count_query_o,
    output logic [DATA_W-1:0]        last_o,
    output logic [DATA_W-1:0]        min_o,
    output logic [TIME_W-1:0]        min_time_o,
    output logic [DATA_W-1:0]        max_o,
    output logic [TIME_W-1:0]        max_time_o,
    output logic [DATA_W-1:0]        avg_o,
    output logic [15:0]              cnt_o,
    output logic [DATA_W-1:0]        span_query_o
);
    typedef enum logic [2:0] {ESS_IDLE, ESS_WAIT_SWEEP, ESS_FIND,
        ESS_DELAY, ESS_PULSE, ESS_WAIT_ADV, ESS_DIG} ess_state_t;

    ess_state_t          state_ff;
    logic [1:0]          sweep_src_ff, step_src_ff;
    logic [15:0]         sweeps_ff;
    logic [CH_BITS-1:0]  ch_ff;
    logic [15:0]         ms_left_ff;
    logic [31:0]         div_ff;
    logic [7:0]          pw_ff;
    logic [15:0]         delay_q [NUM_CH];
    logic [TIME_W-1:0]   time_ff;
    logic                settled_ff;
    ess_store_if         st_if ();

    // Next listed channel at or after a position
    function automatic logic [CH_BITS-1:0] next_ch(
        input logic [NUM_CH-1:0] lst, input logic [CH_BITS-1:0] from);
        logic [CH_BITS-1:0] r;
        r = CH_BITS'(NUM_CH);
        for (int i = NUM_CH - 1; i >= 0; i--)
            if (i >= int'(from) && lst[i])
                r = CH_BITS'(i);
        return r;
    endfunction : next_ch

    logic [CH_BITS-1:0]  nxt_ch;
    logic                list_end;
    logic                ms_tick;
    logic                sweep_evt;
    logic                step_evt;
    logic                is_dig;
    logic                meter_free;
    logic                last_dig;
    // Ascending walk; list order in slot 100..300 is index order
    assign nxt_ch     = next_ch(scan_list_i, ch_ff);
    assign list_end   = (nxt_ch == CH_BITS'(NUM_CH));
    assign ms_tick    = (div_ff == 32'(MS_DIV - 1));
    assign sweep_evt  = (sweep_src_ff == SRC_TIMER) ? timer_tick_i
                                     : src_event_i[sweep_src_ff];
    assign step_evt   = src_event_i[step_src_ff];
    assign is_dig     = digital_ch_i[ch_ff];
    assign meter_free = !internal_meter_on_i;
    assign last_dig   = (ch_ff[4:0] == 5'h1F) || !digital_ch_i[ch_ff + 1'b1];

    // Source selection; equal sources are refused
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sweep_src_ff <= SRC_TIMER;
            step_src_ff  <= 2'h1;
            cfg_err_o    <= 1'b0;
        end
        else if (cfg_wr_i)
        begin
            if (step_source_select_i == sweep_source_select_i)
                cfg_err_o <= 1'b1;
            else
            begin
                cfg_err_o    <= 1'b0;
                sweep_src_ff <= sweep_source_select_i;
                step_src_ff  <= step_source_select_i;
            end
        end
    end

    // Per-channel delay table, 1 ms units, clipped at 60 s
    // Reset so that an unprogrammed channel never stalls the delay count
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            for (int i = 0; i < NUM_CH; i++)
                delay_q[i] <= DELAY_RST;
        else if (delay_wr_i)
            delay_q[delay_ch_i] <= (delay_ms_i > 16'(DELAY_MAX_MS))
                ? 16'(DELAY_MAX_MS) : delay_ms_i;
    end

    // Main scan state machine
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_ff   <= ESS_IDLE;
            ch_ff      <= '0;
            sweeps_ff  <= 16'h0000;
            ms_left_ff <= DELAY_RST;
            div_ff     <= 32'h0000_0000;
            pw_ff      <= 8'h00;
            settled_ff <= 1'b0;
            time_ff    <= '0;
        end
        else
        begin
            time_ff    <= time_ff + 1'b1;
            div_ff     <= ms_tick ? 32'h0000_0000 : div_ff + 32'h0000_0001;
            settled_ff <= 1'b0;
            case (state_ff)
                ESS_IDLE:
                    if (scan_start_i && meter_free)
                    begin
                        sweeps_ff <= 16'h0000;
                        time_ff   <= '0;
                        state_ff  <= ESS_WAIT_SWEEP;
                    end
                ESS_WAIT_SWEEP:
                    if (sweeps_ff >= sweep_total_setting_i)
                        state_ff <= ESS_IDLE;
                    else if (sweep_evt)
                    begin
                        ch_ff    <= '0;
                        state_ff <= ESS_FIND;
                    end
                ESS_FIND:
                    if (list_end)
                    begin
                        sweeps_ff <= sweeps_ff + 16'h0001;
                        state_ff  <= ESS_WAIT_SWEEP;
                    end
                    else
                    begin
                        ch_ff      <= nxt_ch;
                        ms_left_ff <= delay_q[nxt_ch];
                        div_ff     <= 32'h0000_0000;
                        state_ff   <= ESS_DELAY;
                    end
                ESS_DELAY:
                    if (ms_left_ff == 16'h0000)
                    begin
                        pw_ff      <= 8'(PULSE_W);
                        settled_ff <= 1'b1;
                        state_ff   <= ESS_PULSE;
                    end
                    else if (ms_tick)
                        ms_left_ff <= ms_left_ff - 16'h0001;
                ESS_PULSE:
                    if (pw_ff > 8'h01)
                    begin
                        settled_ff <= 1'b1;
                        pw_ff      <= pw_ff - 8'h01;
                    end
                    else
                        state_ff <= ESS_WAIT_ADV;
                ESS_WAIT_ADV:
                    if (step_evt)
                    begin
                        if (is_dig)
                            state_ff <= ESS_DIG;
                        else
                        begin
                            ch_ff    <= ch_ff + 1'b1;
                            state_ff <= ESS_FIND;
                        end
                    end
                ESS_DIG:
                    begin
                        ch_ff <= ch_ff + 1'b1;
                        if (last_dig)
                            state_ff <= ESS_FIND;
                    end
                default:
                    state_ff <= ESS_IDLE;
            endcase
        end
    end

    // Only digital reads enter the store during external scans
    assign st_if.wr    = (state_ff == ESS_DIG) && scan_list_i[ch_ff];
    assign st_if.ch    = ch_ff;
    assign st_if.data  = digital_data_i;
    assign st_if.stamp = time_ff;

    ess_store #(.DEPTH(DEPTH)) u_store (
        .core_clk_i  (core_clk_i),
        .arst_n_i    (arst_n_i),
        .wr_if       (st_if),
        .clear_i     (scan_start_i && state_ff == ESS_IDLE),
        .fetch_i     (fetch_i),
        .fetch_idx_i (fetch_idx_i),
        .remove_i    (remove_i),
        .rd_data_o   (rd_data_o),
        .count_o     (stored_count_query_o)
    );

    // Per-channel statistics
    logic [DATA_W-1:0] s_last [NUM_CH];
    logic [DATA_W-1:0] s_min  [NUM_CH];
    logic [DATA_W-1:0] s_max  [NUM_CH];
    logic [TIME_W-1:0] s_mint [NUM_CH];
    logic [TIME_W-1:0] s_maxt [NUM_CH];
    logic [31:0]       s_sum  [NUM_CH];
    logic [15:0]       s_cnt  [NUM_CH];
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            for (int i = 0; i < NUM_CH; i++)
                s_cnt[i] <= 16'h0000; // First write then seeds min/max
        else if (stats_reset_request_i)
            s_cnt[query_ch_i] <= 16'h0000;
        else if (st_if.wr)
        begin
            s_last[ch_ff] <= st_if.data;
            s_cnt[ch_ff]  <= s_cnt[ch_ff] + 16'h0001;
            s_sum[ch_ff]  <= (s_cnt[ch_ff] == 16'h0000 ? 32'h0 : s_sum[ch_ff])
                             + 32'(st_if.data);
            if (s_cnt[ch_ff] == 16'h0000 || st_if.data < s_min[ch_ff])
            begin
                s_min[ch_ff]  <= st_if.data;
                s_mint[ch_ff] <= time_ff;
            end
            if (s_cnt[ch_ff] == 16'h0000 || st_if.data > s_max[ch_ff])
            begin
                s_max[ch_ff]  <= st_if.data;
                s_maxt[ch_ff] <= time_ff;
            end
        end
    end

    // Registered query outputs; reads do not disturb stored data
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            last_o <= '0; min_o <= '0; max_o <= '0; avg_o <= '0;
            min_time_o <= '0; max_time_o <= '0; cnt_o <= 16'h0000;
            span_query_o <= '0;
        end
        else
        begin
            last_o       <= s_last[query_ch_i];
            min_o        <= s_min[query_ch_i];
            max_o        <= s_max[query_ch_i];
            min_time_o   <= s_mint[query_ch_i];
            max_time_o   <= s_maxt[query_ch_i];
            cnt_o        <= s_cnt[query_ch_i];
            avg_o        <= (s_cnt[query_ch_i] == 16'h0000) ? '0 :
                DATA_W'(s_sum[query_ch_i] / 32'(s_cnt[query_ch_i]));
            span_query_o <= s_max[query_ch_i] - s_min[query_ch_i];
        end
    end

    // Outputs from flops
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            settled_o    <= 1'b0;
            scanning_o   <= 1'b0;
            chan_o       <= '0;
            sense_chan_o <= '0;
            sweep_done_o <= 16'h0000;
        end
        else
        begin
            settled_o    <= settled_ff;
            scanning_o   <= (state_ff != ESS_IDLE);
            chan_o       <= ch_ff;
            sense_chan_o <= paired_sense_enable_i ? ch_ff + (narrow_module_i
                ? CH_BITS'(PAIR_NARROW) : CH_BITS'(PAIR_WIDE)) : ch_ff;
            sweep_done_o <= sweeps_ff;
        end
    end

    sequence s_settle; state_ff == ESS_DELAY && ms_left_ff == 16'h0000; endsequence
    AST_SETTLE_PULSE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        s_settle |=> settled_ff)
        else $error("no settled pulse after delay");
    AST_NO_EARLY_ADV: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_ff == ESS_PULSE && pw_ff > 8'h01 |=> state_ff == ESS_PULSE)
        else $error("advance taken during pulse");
    AST_STEP: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_ff == ESS_WAIT_ADV && step_evt && !is_dig
        |=> state_ff == ESS_FIND && ch_ff == $past(ch_ff) + 1'b1)
        else $error("advance did not step channel");
    AST_SWEEP_STOP: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_ff == ESS_WAIT_SWEEP && sweeps_ff >= sweep_total_setting_i
        |=> state_ff == ESS_IDLE)
        else $error("scan did not stop at sweep total");
    AST_SRC_ERR: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        cfg_wr_i && step_source_select_i == sweep_source_select_i
        |=> cfg_err_o && $stable(step_src_ff))
        else $error("equal sources accepted");
    AST_NO_MUX_STORE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        st_if.wr |-> state_ff == ESS_DIG)
        else $error("multiplexer reading stored");
    AST_LIST_ONLY: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_ff == ESS_FIND && !list_end |=> scan_list_i[ch_ff])
        else $error("unlisted channel visited");
    AST_PAIR: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        paired_sense_enable_i && !narrow_module_i
        |=> sense_chan_o == $past(ch_ff) + CH_BITS'(PAIR_WIDE))
        else $error("four-wire pairing wrong");
endmodule : ess_sequencer
`default_nettype wire

//--- ess_pkg.sv
package ess_pkg;
    localparam int          CLK_MHZ       = 200;
    localparam int          MS_CYCLES     = CLK_MHZ * 1000;
    localparam int          DELAY_MAX_MS  = 60000;
    localparam int          PULSE_CYCLES  = 4;
    localparam int          CH_BITS       = 7;   // slot(2) : chan(5)
    localparam int          NUM_CH        = 96;
    localparam int          SLOT_CH       = 32;
    localparam int          PAIR_WIDE     = 10;
    localparam int          PAIR_NARROW   = 8;
    localparam int          DATA_W        = 16;
    localparam int          TIME_W        = 32;
    localparam logic [1:0]  SRC_TIMER     = 2'h0;
    localparam logic [15:0] DELAY_RST     = 16'h0000;
    typedef enum logic [1:0] {ESS_SRC_TIMER, ESS_SRC_EXT,
                              ESS_SRC_BUS, ESS_SRC_ALARM} ess_src_t;
endpackage : ess_pkg

//--- ess_store_if.sv
`timescale 1ns/100ps
`default_nettype none
// Write port from sequencer into reading store
interface ess_store_if;
    import ess_pkg::*;
    logic                wr;
    logic [CH_BITS-1:0]  ch;
    logic [DATA_W-1:0]   data;
    logic [TIME_W-1:0]   stamp;
    modport seq (output wr, ch, data, stamp);
    modport mem (input  wr, ch, data, stamp);
endinterface : ess_store_if
`default_nettype wire

//--- ess_store.sv
`timescale 1ns/100ps
`default_nettype none
// Circular reading store with fetch and remove-oldest
module ess_store
    import ess_pkg::*;
#(
    parameter int DEPTH = 64
)(
    input  wire logic              core_clk_i,
    input  wire logic              arst_n_i,
    ess_store_if.mem               wr_if,
    input  wire logic              clear_i,
    input  wire logic              fetch_i,
    input  wire logic [15:0]       fetch_idx_i,
    input  wire logic              remove_i,
    output logic [DATA_W-1:0]      rd_data_o,
    output logic [15:0]            count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [AW-1:0]     head_ff;
    logic [15:0]       cnt_ff;
    logic [AW-1:0]     fetch_ptr;
    logic              full;
    assign full      = (cnt_ff == 16'(DEPTH));
    assign fetch_ptr = head_ff + fetch_idx_i[AW-1:0];
    assign count_o   = cnt_ff;
    // Data array, no reset needed
    always_ff @(posedge core_clk_i)
    begin
        if (wr_if.wr)
            mem_q[AW'(head_ff + cnt_ff[AW-1:0])] <= wr_if.data;
    end
    // Head/count: full store drops oldest, remove pops oldest unless a write lands in the same cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            head_ff   <= '0;
            cnt_ff    <= 16'h0000;
            rd_data_o <= '0;
        end
        else if (clear_i)
        begin
            head_ff <= '0;
            cnt_ff  <= 16'h0000;
        end
        else
        begin
            if (fetch_i || remove_i)
                rd_data_o <= mem_q[remove_i ? head_ff : fetch_ptr];
            if (wr_if.wr && full)
                head_ff <= head_ff + 1'b1;
            else if (wr_if.wr)
                cnt_ff <= cnt_ff + 16'h0001;
            else if (remove_i && cnt_ff != 16'h0000)
            begin
                head_ff <= head_ff + 1'b1;
                cnt_ff  <= cnt_ff - 16'h0001;
            end
        end
    end
    AST_FULL_WRAP: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        full && wr_if.wr && !clear_i |=> full)
        else $error("store count fell on overwrite");
    AST_FETCH_KEEP: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        fetch_i && !remove_i && !wr_if.wr && !clear_i |=> $stable(cnt_ff))
        else $error("fetch changed count");
endmodule : ess_store
`default_nettype wire

//--- ess_meter_model.sv
`timescale 1ns/100ps
`default_nettype none
// Outside instrument: measures after each settle pulse, then asks to advance
module ess_meter_model
#(
    parameter int MEAS_CYCLES = 6,
    parameter int SLOW_CYCLES = 40
)(
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    input  wire logic settled_i,
    input  wire logic slow_i,
    output logic      adv_o
);
    int   wait_ff;
    logic busy_ff;

    // Measurement time exceeds the pulse width, so one pulse starts one job
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wait_ff <= 0;
            busy_ff <= 1'b0;
            adv_o   <= 1'b0;
        end
        else
        begin
            adv_o <= 1'b0;
            if (settled_i && !busy_ff)
            begin
                busy_ff <= 1'b1;
                wait_ff <= slow_i ? SLOW_CYCLES : MEAS_CYCLES;
            end
            else if (busy_ff && wait_ff == 0)
            begin
                busy_ff <= 1'b0;
                adv_o   <= 1'b1;
            end
            else if (busy_ff)
            begin
                wait_ff <= wait_ff - 1;
            end
        end
    end
endmodule : ess_meter_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ess_pkg::*;
    localparam int PW = 4;
    logic core_clk_i, arst_n_i, scan_start_i, meter_on, pair_en, narrow;
    logic cfg_wr, delay_wr, timer_tick_i, fetch_i, remove_i, st_rst;
    logic tb_adv, adv, slow, settled_o, scanning_o, cfg_err_o, set_q;
    logic [1:0]         sw_src, st_src;
    logic [15:0]        sweeps, delay_ms, fetch_idx, sweep_done_o, count_o;
    logic [NUM_CH-1:0]  list, dig;
    logic [CH_BITS-1:0] delay_ch, query_ch, chan_o, sense_o, prev_ch;
    logic [DATA_W-1:0]  dig_data, rd_o, last_o, min_o, max_o, avg_o, span_o;
    logic [15:0]        cnt_o;
    logic [TIME_W-1:0]  mint, maxt;
    logic [CH_BITS-1:0] seen_ch[$], seen_sense[$];
    int                 seen_gap[$];
    int                 num_errors, check_count, cyc, plen, gap;

    ess_sequencer #(.DEPTH(4), .MS_DIV(2), .PULSE_W(PW)) u_dut (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .scan_start_i(scan_start_i), .internal_meter_on_i(meter_on),
        .scan_list_i(list), .digital_ch_i(dig),
        .paired_sense_enable_i(pair_en), .narrow_module_i(narrow),
        .cfg_wr_i(cfg_wr), .sweep_source_select_i(sw_src),
        .step_source_select_i(st_src), .sweep_total_setting_i(sweeps),
        .delay_wr_i(delay_wr), .delay_ch_i(delay_ch), .delay_ms_i(delay_ms),
        .timer_tick_i(timer_tick_i), .src_event_i({2'b00, adv | tb_adv, 1'b0}),
        .digital_data_i(dig_data), .fetch_i(fetch_i), .fetch_idx_i(fetch_idx),
        .remove_i(remove_i), .query_ch_i(query_ch),
        .stats_reset_request_i(st_rst), .settled_o(settled_o),
        .scanning_o(scanning_o), .chan_o(chan_o), .sense_chan_o(sense_o),
        .cfg_err_o(cfg_err_o), .sweep_done_o(sweep_done_o), .rd_data_o(rd_o),
        .stored_count_query_o(count_o), .last_o(last_o), .min_o(min_o),
        .min_time_o(mint), .max_o(max_o), .max_time_o(maxt), .avg_o(avg_o),
        .cnt_o(cnt_o), .span_query_o(span_o));

    ess_meter_model u_meter (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .settled_i(settled_o), .slow_i(slow), .adv_o(adv));

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        if (num_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // Clock, periodic timer source, settle pulse monitor and watchdog
    initial
    begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        cyc++;
        timer_tick_i <= (cyc % 16 == 0);
        set_q <= settled_o;
        prev_ch <= chan_o;
        gap = (chan_o != prev_ch) ? 0 : gap + 1;
        // Judge the width before the run counter restarts
        if (!settled_o && set_q)
            chk("pulse width", PW, plen);
        plen = settled_o ? plen + 1 : 0;
        if (settled_o && !set_q)
        begin
            seen_ch.push_back(chan_o);
            seen_sense.push_back(sense_o);
            seen_gap.push_back(gap);
        end
        if (cyc == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick

    // Load levels, pulse start, then wait for the scan to finish (bounded)
    task automatic run_scan(input logic [NUM_CH-1:0] l, input logic [15:0] n);
        int k;
        seen_ch.delete();
        seen_sense.delete();
        seen_gap.delete();
        @(posedge core_clk_i);
        list <= l;
        sweeps <= n;
        scan_start_i <= 1'b1;
        @(posedge core_clk_i);
        scan_start_i <= 1'b0;
        k = 0;
        while (chan_o !== CH_BITS'(l == 96'h1 << 3 | 96'h1 << 40 | 96'h1 << 70
               ? 3 : 127) && k < 200)
        begin
            @(posedge core_clk_i);
            k++;
        end
        tb_adv <= (k < 200); // early advance, before any settle pulse
        @(posedge core_clk_i);
        tb_adv <= 1'b0;
        k = 0;
        while (scanning_o !== 1'b0 && k < 5000)
        begin
            @(posedge core_clk_i);
            k++;
        end
        chk("scan ended", 1, k < 5000);
    endtask : run_scan

    task automatic t_mux_scan();
        @(posedge core_clk_i);
        delay_wr <= 1'b1;
        delay_ch <= 7'h03;
        delay_ms <= 16'h0005;
        tick(1);
        delay_wr <= 1'b0;
        run_scan(96'h1 << 3 | 96'h1 << 40 | 96'h1 << 70, 16'h0002);
        chk("settle count", 6, seen_ch.size());
        for (int i = 0; i < seen_ch.size(); i++)
            chk("channel order", i % 3 == 0 ? 3 : (i % 3 == 1 ? 40 : 70),
                seen_ch[i]);
        chk("delay honoured", 1, seen_gap[0] >= 10);
        chk("sweeps", 2, sweep_done_o);
        chk("mux stored", 0, count_o);
    endtask : t_mux_scan

    task automatic t_refuse();
        meter_on <= 1'b1;
        scan_start_i <= 1'b1;
        tick(1);
        scan_start_i <= 1'b0;
        tick(3);
        chk("start blocked", 0, scanning_o);
        meter_on <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            cfg_wr <= 1'b1;
            sw_src <= (i < 4) ? 2'(i) : 2'h0;
            st_src <= (i < 4) ? 2'(i) : 2'h1;
            tick(1);
            cfg_wr <= 1'b0;
            tick(2);
            chk("source clash", i < 4, cfg_err_o);
        end
    endtask : t_refuse

    task automatic t_pair();
        pair_en <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            narrow <= 1'(i);
            slow <= 1'(i);
            run_scan(96'h1 << 5, 16'h0001);
            chk("pair source", 5, seen_ch[0]);
            chk("pair sense", i ? 13 : 15, seen_sense[0]);
        end
        pair_en <= 1'b0;
    endtask : t_pair

    task automatic t_digital();
        dig <= 96'h3F << 64;
        dig_data <= 16'h00A5;
        run_scan(96'h3F << 64, 16'h0001);
        chk("one advance", 1, seen_ch.size() <= 1);
        chk("count full", 4, count_o);
        for (int i = 0; i < 4; i++)
        begin
            fetch_i <= 1'b1;
            fetch_idx <= 16'(i);
            tick(1);
            fetch_i <= 1'b0;
            tick(1);
            chk("fetch data", 16'h00A5, rd_o);
        end
        chk("fetch keeps", 4, count_o);
        query_ch <= 7'h45;
        tick(2);
        chk("last", 16'h00A5, last_o);
        chk("min", 16'h00A5, min_o);
        chk("max", 16'h00A5, max_o);
        chk("min time", mint, maxt);
        chk("avg", 16'h00A5, avg_o);
        chk("span", 0, span_o);
        chk("cnt", 1, cnt_o);
        st_rst <= 1'b1;
        tick(1);
        st_rst <= 1'b0;
        tick(2);
        chk("cnt cleared", 0, cnt_o);
        remove_i <= 1'b1;
        tick(1);
        remove_i <= 1'b0;
        tick(2);
        chk("removed data", 16'h00A5, rd_o);
        chk("count after remove", 3, count_o);
    endtask : t_digital

    initial
    begin
        {arst_n_i, scan_start_i, meter_on, pair_en, narrow, cfg_wr} = '0;
        {delay_wr, fetch_i, remove_i, st_rst, tb_adv} = '0;
        {slow, sw_src, st_src, sweeps, delay_ms, fetch_idx} = '0;
        {list, dig, delay_ch, query_ch, dig_data} = '0;
        tick(5);
        arst_n_i <= 1'b1;
        tick(1);
        t_mux_scan();
        t_refuse();
        t_pair();
        t_digital();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
